/* File: addr_gen_cfg.svh */
// constants for the dual operand address generator
`ifndef ADDR_GEN_CFG_SVH
`define ADDR_GEN_CFG_SVH

// ---------------------------------------------------------------
// widths and counts
// ---------------------------------------------------------------
`define AG_ADDR_W 32
`define AG_NUM_REGS 8
`define AG_IDX_W 3
`define AG_REG_RESET 32'h0000_0000

// ---------------------------------------------------------------
// mode control bit positions (secondary set select per generator)
// ---------------------------------------------------------------
`define AG_MODE_SEC_FIRST 0
`define AG_MODE_SEC_SECOND 1

`endif

/* File: addr_gen_pkg.sv */
// types shared by the dual operand address generator
`default_nettype none
package addr_gen_pkg;

  // ---------------------------------------------------------------
  // register classes a write can target
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CLS_POINTER = 2'h0,
    CLS_MODIFIER = 2'h1,
    CLS_BASE = 2'h2,
    CLS_LENGTH = 2'h3
  } reg_class_t;

  // one access request per generator for a cycle
  typedef struct packed {
    logic valid;          // an access happens this cycle
    logic indirect;       // generator output rather than immediate
    logic pre_modify;     // modify before the access
    logic update;         // write the modified pointer back
    logic [2:0] ptr_sel;  // pointer and base/length select
    logic [2:0] mod_sel;  // modifier select
    logic [31:0] direct_addr; // absolute address from the instruction
  } access_req_t;

  // register load request from the decoder
  typedef struct packed {
    logic valid;          // write strobe
    logic gen;            // 0 first generator, 1 second
    reg_class_t cls;      // which bank
    logic [2:0] idx;      // which register
    logic [31:0] data;    // value to store
  } reg_write_t;

  // address presented on a bus
  typedef struct packed {
    logic valid;          // address valid
    logic [31:0] addr;    // operand address
  } bus_addr_t;

endpackage : addr_gen_pkg
`default_nettype wire

/* File: dual_data_address_generator.sv */
// dual operand address generator with circular buffering and shadow sets
`include "addr_gen_cfg.svh"
`default_nettype none
module dual_data_address_generator #(
  parameter int NUM_REGS = `AG_NUM_REGS  // registers per bank
) (
  input wire logic clk_i,                             // core clock
  input wire logic nrst_i,                            // sync reset, active low
  input wire logic [1:0] mode_sec_i,                  // secondary select bits
  input wire addr_gen_pkg::access_req_t req_dm_i,     // first generator request
  input wire addr_gen_pkg::access_req_t req_pm_i,     // second generator request
  input wire addr_gen_pkg::reg_write_t wr_i,          // register load
  output addr_gen_pkg::bus_addr_t data_memory_bus_o,  // data bus address
  output addr_gen_pkg::bus_addr_t program_memory_bus_o, // program bus address
  output logic circ_ovf_irq_o                         // overflow pulse
);
  import addr_gen_pkg::*;

  initial begin
    if (NUM_REGS != `AG_NUM_REGS) $error("only eight registers per bank supported");
  end

  // ---------------------------------------------------------------
  // register banks: [generator][set][index]
  // ---------------------------------------------------------------
  logic [31:0] ptr_q [2][2][NUM_REGS]; // pointers
  logic [31:0] mod_q [2][2][NUM_REGS]; // modifiers
  logic [31:0] base_q [2][2][NUM_REGS]; // buffer bases
  logic [31:0] len_q [2][2][NUM_REGS]; // buffer lengths
  logic [1:0] mode_q; // registered set select
  logic [1:0] wrap_d; // overflow per generator this cycle
  logic [31:0] next_ptr_d [2]; // updated pointers
  logic [31:0] addr_d [2]; // addresses to present

  // ---------------------------------------------------------------
  // modulo update: any base, no alignment needed
  // ---------------------------------------------------------------
  function automatic logic [32:0] circ_update(input logic [31:0] p, input logic [31:0] m,
                                              input logic [31:0] b, input logic [31:0] l);
    logic [31:0] sum;
    logic [31:0] top;
    sum = p + m;
    top = b + l;
    // wrap flag in bit 32
    if (l == 32'h0000_0000) begin
      circ_update = {1'b0, sum}; // linear when length is zero
    end else if ($signed(m) >= 0 && $signed(sum - top) >= 0) begin
      circ_update = {1'b1, sum - l}; // past end: subtract length
    end else if ($signed(m) < 0 && $signed(sum - b) < 0) begin
      circ_update = {1'b1, sum + l}; // below base: add length
    end else begin
      circ_update = {1'b0, sum};
    end
  endfunction

  // ---------------------------------------------------------------
  // set select: primary after reset, secondary on mode bits
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_q <= 2'h0;
    end else begin
      mode_q <= mode_sec_i;
    end
  end

  // ---------------------------------------------------------------
  // address and update compute, both generators in parallel
  // ---------------------------------------------------------------
  always_comb begin
    access_req_t r;
    logic [32:0] u;
    logic s;
    r = req_dm_i;
    u = 33'h0;
    s = 1'b0;
    for (int g = 0; g < 2; g++) begin
      r = (g == 0) ? req_dm_i : req_pm_i;
      s = mode_q[g];
      u = circ_update(ptr_q[g][s][r.ptr_sel], mod_q[g][s][r.mod_sel],
                      base_q[g][s][r.ptr_sel], len_q[g][s][r.ptr_sel]);
      next_ptr_d[g] = u[31:0];
      wrap_d[g] = r.valid && r.indirect && u[32];
      if (!r.indirect) begin
        addr_d[g] = r.direct_addr; // direct addressing
      end else if (r.pre_modify) begin
        addr_d[g] = u[31:0]; // pre-modify
      end else begin
        addr_d[g] = ptr_q[g][s][r.ptr_sel]; // post-modify
      end
    end
  end

  // ---------------------------------------------------------------
  // bank storage; pointer update beats a load to the same pointer
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    access_req_t r;
    if (!nrst_i) begin
      for (int g = 0; g < 2; g++) begin
        for (int s = 0; s < 2; s++) begin
          for (int i = 0; i < NUM_REGS; i++) begin
            ptr_q[g][s][i] <= `AG_REG_RESET;
            mod_q[g][s][i] <= `AG_REG_RESET;
            base_q[g][s][i] <= `AG_REG_RESET;
            len_q[g][s][i] <= `AG_REG_RESET;
          end
        end
      end
    end else begin
      // loads go to the active set of the named generator
      if (wr_i.valid) begin
        case (wr_i.cls)
          CLS_POINTER: ptr_q[wr_i.gen][mode_q[wr_i.gen]][wr_i.idx] <= wr_i.data;
          CLS_MODIFIER: mod_q[wr_i.gen][mode_q[wr_i.gen]][wr_i.idx] <= wr_i.data;
          CLS_BASE: begin
            base_q[wr_i.gen][mode_q[wr_i.gen]][wr_i.idx] <= wr_i.data;
            ptr_q[wr_i.gen][mode_q[wr_i.gen]][wr_i.idx] <= wr_i.data; // start at base
          end
          CLS_LENGTH: len_q[wr_i.gen][mode_q[wr_i.gen]][wr_i.idx] <= wr_i.data;
          default: ;
        endcase
      end
      for (int g = 0; g < 2; g++) begin
        r = (g == 0) ? req_dm_i : req_pm_i;
        if (r.valid && r.indirect && r.update) begin
          ptr_q[g][mode_q[g]][r.ptr_sel] <= next_ptr_d[g];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // registered outputs on both buses
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      data_memory_bus_o <= '0;
      program_memory_bus_o <= '0;
      circ_ovf_irq_o <= 1'b0;
    end else begin
      data_memory_bus_o <= '{valid: req_dm_i.valid, addr: addr_d[0]};
      program_memory_bus_o <= '{valid: req_pm_i.valid, addr: addr_d[1]};
      circ_ovf_irq_o <= |wrap_d;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_direct_dm_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_dm_i.valid && !req_dm_i.indirect
    |=> data_memory_bus_o.addr == $past(req_dm_i.direct_addr))
    else $error("direct address not presented on data bus");
  a_direct_pm_addr: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_pm_i.valid && !req_pm_i.indirect
    |=> program_memory_bus_o.addr == $past(req_pm_i.direct_addr))
    else $error("direct address not presented on program bus");
  a_dual_valid_same: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_dm_i.valid && req_pm_i.valid |=> data_memory_bus_o.valid && program_memory_bus_o.valid)
    else $error("both buses must carry addresses together");
  a_ovf_irq_cause: assert property (@(posedge clk_i) disable iff (!nrst_i)
    circ_ovf_irq_o |-> $past(wrap_d) != 2'h0)
    else $error("overflow without wrap");
  a_primary_after_reset: assert property (@(posedge clk_i)
    !nrst_i |=> mode_q == 2'h0)
    else $error("primary set not active after reset");
  a_wrap_in_buffer: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wrap_d[0] && req_dm_i.pre_modify
    |=> data_memory_bus_o.addr >= $past(base_q[0][mode_q[0]][req_dm_i.ptr_sel]))
    else $error("wrapped address below base");
  a_post_uses_old: assert property (@(posedge clk_i) disable iff (!nrst_i)
    req_dm_i.valid && req_dm_i.indirect && !req_dm_i.pre_modify
    |=> data_memory_bus_o.addr == $past(ptr_q[0][mode_q[0]][req_dm_i.ptr_sel]))
    else $error("post-modify address not the old pointer");
  a_linear_no_len: assert property (@(posedge clk_i) disable iff (!nrst_i)
    len_q[1][mode_q[1]][req_pm_i.ptr_sel] == 32'h0 |-> !wrap_d[1])
    else $error("wrap with zero length");

endmodule // dual_data_address_generator
`default_nettype wire

/* File: dual_data_address_generator_test.sv */
// self-checking bench for the dual operand address generator
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module dual_data_address_generator_test;
  import addr_gen_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 0, nrst_i = 0, irq, we[2], pw[2];
  logic [1:0] mode_sec_i = '0, msel = '0; // msel mirrors the active set per generator
  access_req_t req_dm_i = '0, req_pm_i = '0;
  reg_write_t wr_i = '0;
  bus_addr_t dm_o, pm_o, eb[2], pb[2];
  logic [31:0] dm_cnt, pm_cnt, p_m[2][2][8], m_m[2][2][8], b_m[2][2][8], l_m[2][2][8];
  int err_count = 0, samples_checked = 0, issued = 0;
  dual_data_address_generator dut_u (.clk_i(clk_i), .nrst_i(nrst_i), .mode_sec_i(mode_sec_i),
    .req_dm_i(req_dm_i), .req_pm_i(req_pm_i), .wr_i(wr_i), .data_memory_bus_o(dm_o),
    .program_memory_bus_o(pm_o), .circ_ovf_irq_o(irq));
  operand_bus_sink sink_u (.clk_i(clk_i), .nrst_i(nrst_i), .dm_i(dm_o), .pm_i(pm_o),
    .dm_cnt_o(dm_cnt), .pm_cnt_o(pm_cnt));
  always #5 clk_i = ~clk_i;
  // ---------------------------------------------------------------
  // register loads, mirrored into the model of the active set
  // ---------------------------------------------------------------
  task automatic load(input int g, input reg_class_t c, input int i, input logic [31:0] d);
    @(posedge clk_i) wr_i <= '{valid: 1'b1, gen: g[0], cls: c, idx: i[2:0], data: d};
    @(posedge clk_i) wr_i <= '0;
    if (c == CLS_POINTER || c == CLS_BASE) p_m[g][msel[g]][i] = d; // base load also sets pointer
    if (c == CLS_MODIFIER) m_m[g][msel[g]][i] = d;
    if (c == CLS_BASE) b_m[g][msel[g]][i] = d;
    if (c == CLS_LENGTH) l_m[g][msel[g]][i] = d;
  endtask
  // random request plus its expected address and wrap flag
  function automatic access_req_t mk(input int g, output bus_addr_t e, output logic w);
    access_req_t r;
    logic [31:0] n, p, m, b, l;
    r = '{valid: 1'b1, indirect: ($urandom % 4 != 0), pre_modify: $urandom, update: 1'b1,
      ptr_sel: $urandom, mod_sel: 3'h0, direct_addr: $urandom};
    r.mod_sel = r.ptr_sel; // keeps the step within the buffer length
    {p, m, b, l} = {p_m[g][msel[g]][r.ptr_sel], m_m[g][msel[g]][r.ptr_sel],
      b_m[g][msel[g]][r.ptr_sel], l_m[g][msel[g]][r.ptr_sel]};
    n = p + m;
    w = 1'b0;
    if (l != 0 && !m[31] && n >= b + l) begin
      n = n - l;
      w = r.indirect;
    end else if (l != 0 && m[31] && n < b) begin
      n = n + l;
      w = r.indirect;
    end
    e = '{valid: 1'b1, addr: r.indirect ? (r.pre_modify ? n : p) : r.direct_addr};
    if (r.indirect) p_m[g][msel[g]][r.ptr_sel] = n;
    issued += g;
    return r;
  endfunction
  task automatic check_prev();
    `CHK(dm_o, pb[0])
    `CHK(pm_o, pb[1])
    `CHK(irq, pw[0] | pw[1])
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // main sequence: reset, then random buffer setups and request bursts
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] l, b;
    void'($urandom(32'hbc37991b));
    for (int g = 0; g < 2; g++) for (int s = 0; s < 2; s++) for (int i = 0; i < 8; i++)
      {p_m[g][s][i], m_m[g][s][i], b_m[g][s][i], l_m[g][s][i]} = '0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1 `CHK({dm_o.valid, pm_o.valid, irq}, 3'h0)
    for (int t = 0; t < 24; t++) begin
      msel = (t == 0) ? 2'h0 : 2'($urandom); // first setup stays on the primary set
      @(posedge clk_i) mode_sec_i <= msel;
      repeat (2) @(posedge clk_i);
      for (int g = 0; g < 2; g++) for (int i = 0; i < 8; i++) begin
        l = ($urandom % 4 == 0) ? 32'h0 : 32'h1 + $urandom % 64;
        b = $urandom_range(32'h7fff_0000, 32'h1000); // any alignment
        load(g, CLS_LENGTH, i, l);
        load(g, CLS_BASE, i, b);
        load(g, CLS_POINTER, i, b + ((l == 0) ? 32'h0 : $urandom % l));
        b = ($urandom % 3 == 0) ? l : $urandom % (l + 1);
        load(g, CLS_MODIFIER, i, $urandom % 2 ? -b : b);
      end
      for (int k = 0; k < 12; k++) begin
        @(posedge clk_i);
        req_dm_i <= mk(0, eb[0], we[0]);
        req_pm_i <= mk(1, eb[1], we[1]);
        #1 if (k > 0) check_prev();
        pb = eb;
        pw = we;
      end
      @(posedge clk_i) {req_dm_i, req_pm_i} <= '0;
      #1 check_prev();
    end
    // the sink counts the last bus cycle one edge after it is presented
    @(posedge clk_i);
    #1 `CHK({dm_cnt, pm_cnt}, {32'(issued), 32'(issued)})
    print_verdict();
  end
  initial begin
    repeat (50000) @(posedge clk_i);
    err_count++;
    print_verdict();
  end
endmodule // dual_data_address_generator_test
`default_nettype wire

/* File: operand_bus_sink.sv */
// partner model: memory side that counts addresses taken on both operand buses
`default_nettype none
module operand_bus_sink
  import addr_gen_pkg::*;
(
  input wire logic clk_i,                 // core clock
  input wire logic nrst_i,                // sync reset, active low
  input wire addr_gen_pkg::bus_addr_t dm_i, // data bus address
  input wire addr_gen_pkg::bus_addr_t pm_i, // program bus address
  output logic [31:0] dm_cnt_o,           // accesses seen on data bus
  output logic [31:0] pm_cnt_o            // accesses seen on program bus
);
  // ---------------------------------------------------------------
  // both ports accept one address every cycle, side by side
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      dm_cnt_o <= 32'h0;
      pm_cnt_o <= 32'h0;
    end else begin
      dm_cnt_o <= dm_cnt_o + 32'(dm_i.valid);
      pm_cnt_o <= pm_cnt_o + 32'(pm_i.valid);
    end
  end
endmodule // operand_bus_sink
`default_nettype wire
